// ==== design/servo_homing_and_window_monitor.sv ====
// Overview of operation
// - Config bit 0 clear searches toward increasing position, set toward decreasing.
// - Config bit 1 picks marker after rising (clear) or falling (set) switch edge.
// - Only drive-wired home switch and motor feedback are supported; bits fixed.
// - Config bit 5 set skips the home switch; clear evaluates it.
// - Config bit 6 set skips the marker pulse; clear evaluates it.
// - Active homing command switches to internal control and ramps to homing speed.
// - Starting homing clears the referenced status bit.
// - Cyclic command changes are ignored while the homing command is active.
// - After the reference marker the drive ramps down to standstill.
// - Success needs standstill and a reference; then referenced status is set.
// - On completion the commanded position is recomputed from the reference mark.
// - Master cancels the command; drive then follows cyclic commands again.
// - An interrupted homing leaves the position unreferenced.
// - A class 1 error during homing gives an error acknowledgement.
// - Speed-reached bit set when feedback lies within window; window 0 to 32768.
// - Deviation error set when position error exceeds window past the delay.
// - Acceleration scaling kind reads as fixed value 2.
// - Acceleration scaling multiplier reads as fixed value 1.
// - Config bit 4 and bits 7 to 15 carry no function.
module servo_homing_and_window_monitor (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Service channel
    input wire logic i_svc_valid,
    input servo_home_pkg::svc_req_t i_svc_req,
    output servo_home_pkg::svc_rsp_t o_svc_rsp,
    // Cyclic commands and feedback
    input wire logic [31:0] i_cyc_pos_cmd,
    input wire logic [31:0] i_cyc_vel_cmd,
    input wire logic [31:0] i_pos_fb,
    input wire logic [31:0] i_vel_fb,
    // Homing motion settings
    input wire logic [31:0] i_homing_velocity,
    input wire logic [31:0] i_homing_accel,
    input wire logic [31:0] i_ref_distance,
    // Diagnostics from the rest of the drive
    input wire logic [15:0] i_ext_class1,
    input wire logic i_class1_reset,
    // Pins
    input wire logic i_home_switch,
    input wire logic i_marker_pulse,
    // Motion and status outputs
    output logic [31:0] o_pos_cmd,
    output logic [31:0] o_vel_cmd,
    output logic o_internal_pos_ctrl,
    output logic o_referenced,
    output servo_home_pkg::proc_ack_t o_proc_ack,
    output logic [15:0] o_class1_diag_word,
    output logic [15:0] o_class3_diag_word
);
    import servo_home_pkg::*;

    home_regs_t r;
    home_regs_t next_r;
    logic [1:0] pins_sync;
    logic sw;
    logic mark;
    logic sw_edge;
    logic mark_rise;
    logic ref_evt;
    logic proc_active;
    logic [31:0] vel_err;
    logic [31:0] pos_err;
    logic [15:0] proc_word;
    logic [15:0] c1_set;
    logic [15:0] c3_now;

    pin_sync2 #(.WIDTH(2)) u_pin_sync (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_pins({i_marker_pulse, i_home_switch}),
        .o_pins(pins_sync)
    );

    // Magnitude of a two's complement difference. The most negative difference maps to
    // itself, which still reads as a very large unsigned error, so the monitors trip.
    function automatic logic [31:0] abs_diff(input logic [31:0] a, input logic [31:0] b);
        logic [31:0] d;
        d = a - b;
        if (d[31]) begin
            return 32'h0000_0000 - d;
        end else begin
            return d;
        end
    endfunction

    assign sw = pins_sync[0];
    assign mark = pins_sync[1];
    // The delayed pin copies reset low, which is the idle level of both pins,
    // so leaving reset never shows a false edge.
    assign mark_rise = mark & ~r.mark_q;
    assign proc_active = (r.proc == PROC_ACTIVE);
    assign vel_err = abs_diff(i_vel_fb, r.vel_out);
    assign pos_err = abs_diff(r.pos_out, i_pos_fb);

    always_comb begin
        // The switch edge that arms the marker search is chosen by config bit 1.
        // The other edge is ignored, so passing the switch the wrong way arms nothing.
        if (r.hcfg[HCFG_EDGE]) begin
            sw_edge = ~sw & r.sw_q;
        end else begin
            sw_edge = sw & ~r.sw_q;
        end
        // With the marker skipped, the switch edge is the reference, or none is awaited when the switch is skipped too.
        if (r.hcfg[HCFG_SKIP_MARK]) begin
            ref_evt = r.hcfg[HCFG_SKIP_SW] | sw_edge;
        end else begin
            ref_evt = r.armed & mark_rise;
        end
        proc_word = 16'h0000;
        proc_word[1:0] = r.proc;
        proc_word[PROC_ACK_DONE] = r.pack.done;
        proc_word[PROC_ACK_BUSY] = r.pack.busy;
        proc_word[PROC_ACK_ERR] = r.pack.error;
        c3_now = 16'h0000;
        c3_now[C3_SPEED_REACHED] = (vel_err <= r.vel_win);
        c1_set = i_ext_class1;
        c1_set[C1_DEVIATION] = (r.dev_cnt >= FOLLOW_DELAY_CYCLES) & (pos_err > r.pos_win);
    end

    always_comb begin
        next_r = r;
        next_r.rsp.ack = 1'b0;
        next_r.rsp.err = 1'b0;
        next_r.sw_q = sw;
        next_r.mark_q = mark;

        // Every request is answered one cycle later, so the master needs no timeout.
        if (i_svc_valid) begin
            next_r.rsp.ack = 1'b1;
            next_r.rsp.rdata = 32'h0000_0000;
            case (i_svc_req.idn)
                IDN_HOMING_CONFIG: begin
                    if (i_svc_req.write) begin
                        next_r.hcfg = i_svc_req.wdata[15:0] & HCFG_WRITABLE;
                    end else begin
                        next_r.rsp.rdata = {16'h0000, r.hcfg | HCFG_FIXED_ONES};
                    end
                end
                IDN_HOMING_PROC: begin
                    if (i_svc_req.write) begin
                        next_r.proc = i_svc_req.wdata[1:0];
                    end else begin
                        next_r.rsp.rdata = {16'h0000, proc_word};
                    end
                end
                IDN_SPEED_WINDOW: begin
                    if (i_svc_req.write) begin
                        // Values above the setting range are clamped, not refused.
                        if (i_svc_req.wdata > SPEED_WIN_MAX) begin
                            next_r.vel_win = SPEED_WIN_MAX;
                        end else begin
                            next_r.vel_win = i_svc_req.wdata;
                        end
                    end else begin
                        next_r.rsp.rdata = r.vel_win;
                    end
                end
                IDN_POS_ERR_WINDOW: begin
                    if (i_svc_req.write) begin
                        next_r.pos_win = {1'b0, i_svc_req.wdata[30:0]};
                    end else begin
                        next_r.rsp.rdata = r.pos_win;
                    end
                end
                IDN_ACCEL_KIND: begin
                    next_r.rsp.err = i_svc_req.write;
                    next_r.rsp.rdata = {16'h0000, ACCEL_KIND_VALUE};
                end
                IDN_ACCEL_MULT: begin
                    next_r.rsp.err = i_svc_req.write;
                    next_r.rsp.rdata = {16'h0000, ACCEL_MULT_VALUE};
                end
                default: begin
                    next_r.rsp.err = 1'b1;
                end
            endcase
        end

        // Homing sequence.
        case (r.st)
            ST_IDLE: begin
                // Control returns to the cyclic values one cycle after idle is reached.
                next_r.internal = 1'b0;
                if (proc_active) begin
                    next_r.st = ST_SEARCH;
                    next_r.internal = 1'b1;
                    next_r.referenced = 1'b0;
                    // Holding the last commanded position keeps the axis from jumping
                    // when homing takes over from the cyclic values.
                    next_r.held_pos = r.pos_out;
                    next_r.spd = 32'h0000_0000;
                    next_r.armed = r.hcfg[HCFG_SKIP_SW];
                    next_r.pack = '{busy: 1'b1, done: 1'b0, error: 1'b0};
                end
            end
            ST_SEARCH: begin
                // The ramp stops at the homing velocity; its last step may be short.
                if (i_homing_velocity - r.spd > i_homing_accel) begin
                    next_r.spd = r.spd + i_homing_accel;
                end else begin
                    next_r.spd = i_homing_velocity;
                end
                if (sw_edge) begin
                    next_r.armed = 1'b1;
                end
                if (ref_evt) begin
                    next_r.ref_pos = i_pos_fb;
                    next_r.st = ST_DECEL;
                end
            end
            ST_DECEL: begin
                if (r.spd > i_homing_accel) begin
                    next_r.spd = r.spd - i_homing_accel;
                end else begin
                    next_r.spd = 32'h0000_0000;
                end
                // Both the ramp and the measured speed must be zero, so a coasting
                // axis is never taken as referenced.
                if (r.spd == 32'h0000_0000 && i_vel_fb == 32'h0000_0000) begin
                    next_r.st = ST_DONE;
                    next_r.referenced = 1'b1;
                    next_r.held_pos = i_pos_fb - r.ref_pos + i_ref_distance;
                    next_r.pack = '{busy: 1'b0, done: 1'b1, error: 1'b0};
                end
            end
            ST_DONE: begin
                // The held position stays until the master cancels the command.
                if (!proc_active) begin
                    next_r.st = ST_IDLE;
                    next_r.pack.done = 1'b0;
                end
            end
            ST_FAULT: begin
                next_r.spd = 32'h0000_0000;
                if (!proc_active) begin
                    next_r.st = ST_IDLE;
                    next_r.pack.error = 1'b0;
                end
            end
            default: begin
                next_r.st = ST_IDLE;
            end
        endcase

        // These checks follow the state case so that they win over a step taken in
        // the same cycle; a cancel takes priority over a class 1 fault.
        if ((r.st == ST_SEARCH) || (r.st == ST_DECEL)) begin
            if (!proc_active) begin
                // Cancelled mid-way: no reference is taken.
                next_r.st = ST_IDLE;
                next_r.referenced = 1'b0;
                next_r.spd = 32'h0000_0000;
                next_r.pack = '{busy: 1'b0, done: 1'b0, error: 1'b0};
            end else if (r.c1 != 16'h0000) begin
                next_r.st = ST_FAULT;
                next_r.referenced = 1'b0;
                next_r.pack = '{busy: 1'b0, done: 1'b0, error: 1'b1};
            end
        end

        // Command outputs: cyclic values pass only outside homing.
        if (next_r.internal) begin
            next_r.pos_out = next_r.held_pos;
            if (r.hcfg[HCFG_DIR]) begin
                next_r.vel_out = 32'h0000_0000 - next_r.spd;
            end else begin
                next_r.vel_out = next_r.spd;
            end
        end else begin
            next_r.pos_out = i_cyc_pos_cmd;
            next_r.vel_out = i_cyc_vel_cmd;
        end

        // Diagnostics; a new error wins over a reset in the same cycle.
        if (pos_err > r.pos_win) begin
            // Saturate so a long excursion cannot wrap the count back under the delay.
            if (r.dev_cnt != 16'hFFFF) begin
                next_r.dev_cnt = r.dev_cnt + 16'h0001;
            end
        end else begin
            next_r.dev_cnt = 16'h0000;
        end
        next_r.c1 = ((i_class1_reset ? 16'h0000 : r.c1) | c1_set);
        next_r.c3 = c3_now;
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            r <= '0;
            r.st <= ST_IDLE;
            r.hcfg <= HCFG_RESET;
            r.proc <= PROC_RESET;
            r.vel_win <= SPEED_WIN_RESET;
            // The position window leaves reset at its widest, so the deviation monitor trips only on
            // the most negative difference until the master programs a real limit.
            r.pos_win <= POS_WIN_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign o_svc_rsp = r.rsp;
    assign o_pos_cmd = r.pos_out;
    assign o_vel_cmd = r.vel_out;
    assign o_internal_pos_ctrl = r.internal;
    assign o_referenced = r.referenced;
    assign o_proc_ack = r.pack;
    assign o_class1_diag_word = r.c1;
    assign o_class3_diag_word = r.c3;
endmodule

// ==== shared/servo_home_pkg.sv ====
package servo_home_pkg;

    // Parameter numbers on the service channel (147, 148, 157, 159, 160, 161).
    localparam logic [15:0] IDN_HOMING_CONFIG = 16'h0093;
    localparam logic [15:0] IDN_HOMING_PROC = 16'h0094;
    localparam logic [15:0] IDN_SPEED_WINDOW = 16'h009D;
    localparam logic [15:0] IDN_POS_ERR_WINDOW = 16'h009F;
    localparam logic [15:0] IDN_ACCEL_KIND = 16'h00A0;
    localparam logic [15:0] IDN_ACCEL_MULT = 16'h00A1;

    // Homing configuration word layout.
    localparam int HCFG_DIR = 0;
    localparam int HCFG_EDGE = 1;
    localparam int HCFG_SKIP_SW = 5;
    localparam int HCFG_SKIP_MARK = 6;
    localparam logic [15:0] HCFG_WRITABLE = 16'h0063;
    localparam logic [15:0] HCFG_FIXED_ONES = 16'h0004;
    localparam logic [15:0] HCFG_RESET = 16'h0000;

    // Procedure command word: set and enable, plus acknowledgement bits on read.
    localparam int PROC_SET = 0;
    localparam int PROC_EN = 1;
    localparam int PROC_ACK_DONE = 8;
    localparam int PROC_ACK_BUSY = 9;
    localparam int PROC_ACK_ERR = 10;
    localparam logic [1:0] PROC_ACTIVE = 2'h3;
    localparam logic [1:0] PROC_RESET = 2'h0;

    localparam logic [31:0] SPEED_WIN_MAX = 32'h0000_8000;
    localparam logic [31:0] SPEED_WIN_RESET = 32'h0000_0000;
    localparam logic [31:0] POS_WIN_RESET = 32'h7FFF_FFFF;
    localparam logic [15:0] ACCEL_KIND_VALUE = 16'h0002;
    localparam logic [15:0] ACCEL_MULT_VALUE = 16'h0001;

    localparam int C1_DEVIATION = 11;
    localparam int C3_SPEED_REACHED = 0;

    // Following error delay; the count is the longest whole number of cycles.
    localparam int CLK_PERIOD_NS = 40;
    localparam int FOLLOW_DELAY_NS = 2000;
    localparam logic [15:0] FOLLOW_DELAY_CYCLES =
        16'((FOLLOW_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 : (FOLLOW_DELAY_NS / CLK_PERIOD_NS));

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_SEARCH = 5'b00010,
        ST_DECEL = 5'b00100,
        ST_DONE = 5'b01000,
        ST_FAULT = 5'b10000
    } home_state_t;

    typedef struct packed {
        logic write;
        logic [15:0] idn;
        logic [31:0] wdata;
    } svc_req_t;

    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] rdata;
    } svc_rsp_t;

    typedef struct packed {
        logic busy;
        logic done;
        logic error;
    } proc_ack_t;

    typedef struct packed {
        home_state_t st;
        logic [15:0] hcfg;
        logic [1:0] proc;
        logic [31:0] vel_win;
        logic [31:0] pos_win;
        svc_rsp_t rsp;
        proc_ack_t pack;
        logic referenced;
        logic internal;
        logic armed;
        logic sw_q;
        logic mark_q;
        logic [31:0] spd;
        logic [31:0] held_pos;
        logic [31:0] ref_pos;
        logic [31:0] pos_out;
        logic [31:0] vel_out;
        logic [15:0] c1;
        logic [15:0] c3;
        logic [15:0] dev_cnt;
    } home_regs_t;

endpackage

// ==== design/pin_sync2.sv ====
module pin_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Asynchronous pins and their synchronised copies
    input wire logic [WIDTH-1:0] i_pins,
    output logic [WIDTH-1:0] o_pins
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } sync_regs_t;

    sync_regs_t r;
    sync_regs_t next_r;

    always_comb begin
        next_r.s1 = i_pins;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign o_pins = r.s2;
endmodule

// ==== tb/servo_home_properties.sv ====
module servo_home_properties (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Service channel
    input wire logic i_svc_valid,
    input servo_home_pkg::svc_rsp_t o_svc_rsp,
    // Commands and feedback
    input wire logic [31:0] i_cyc_pos_cmd,
    input wire logic [31:0] i_pos_fb,
    input wire logic [31:0] i_vel_fb,
    // Outputs under watch
    input wire logic [31:0] o_pos_cmd,
    input wire logic [31:0] o_vel_cmd,
    input wire logic o_internal_pos_ctrl,
    input wire logic o_referenced,
    input servo_home_pkg::proc_ack_t o_proc_ack,
    input wire logic [15:0] o_class1_diag_word,
    input wire logic [15:0] o_class3_diag_word
);
    import servo_home_pkg::*;
    // Counts consecutive cycles of any position error; saturates so it never wraps.
    logic [15:0] off_cnt;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            off_cnt <= 16'h0000;
        end else if (o_pos_cmd == i_pos_fb) begin
            off_cnt <= 16'h0000;
        end else if (off_cnt != 16'hFFFF) begin
            off_cnt <= off_cnt + 16'h0001;
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);
    a_ack_next: assert property (i_svc_valid |=> o_svc_rsp.ack)
        else $error("service request not answered next cycle");
    a_start_unref: assert property ($rose(o_internal_pos_ctrl) |-> !o_referenced)
        else $error("referenced status kept at homing start");
    a_done_ref: assert property (o_proc_ack.done |-> o_referenced)
        else $error("homing done without referenced status");
    a_abort_unref: assert property (
        $fell(o_proc_ack.busy) && !o_proc_ack.done |-> !o_referenced)
        else $error("aborted homing left referenced status set");
    a_class1_err: assert property (
        o_proc_ack.busy && o_class1_diag_word != 16'h0000 |-> ##[0:3] o_proc_ack.error)
        else $error("class 1 error during homing not acknowledged");
    a_speed_hit: assert property (
        $past(i_resetn) && $past(i_vel_fb == o_vel_cmd) |-> o_class3_diag_word[C3_SPEED_REACHED])
        else $error("speed reached bit clear with equal speeds");
    a_follow_cyc: assert property (
        $past(i_resetn) && !o_internal_pos_ctrl && !$past(o_internal_pos_ctrl)
        |-> o_pos_cmd == $past(i_cyc_pos_cmd))
        else $error("position command does not follow cyclic value");
    a_dev_delay: assert property (
        $rose(o_class1_diag_word[C1_DEVIATION]) |-> off_cnt >= FOLLOW_DELAY_CYCLES)
        else $error("deviation error raised before the delay ran out");
endmodule

bind servo_homing_and_window_monitor servo_home_properties i_servo_home_properties (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_svc_valid(i_svc_valid), .o_svc_rsp(o_svc_rsp),
    .i_cyc_pos_cmd(i_cyc_pos_cmd), .i_pos_fb(i_pos_fb), .i_vel_fb(i_vel_fb),
    .o_pos_cmd(o_pos_cmd), .o_vel_cmd(o_vel_cmd), .o_internal_pos_ctrl(o_internal_pos_ctrl),
    .o_referenced(o_referenced), .o_proc_ack(o_proc_ack),
    .o_class1_diag_word(o_class1_diag_word), .o_class3_diag_word(o_class3_diag_word));

// ==== tb/svc_master_model.sv ====
module svc_master_model (
    // Clock
    input wire logic i_clk,
    // Requests toward the drive
    output logic o_svc_valid,
    output servo_home_pkg::svc_req_t o_svc_req,
    // Answers from the drive
    input servo_home_pkg::svc_rsp_t i_svc_rsp
);
    timeunit 1ns;
    timeprecision 1ns;
    import servo_home_pkg::*;
    // Idle cycles before each request; a slow master sets it above zero.
    int gap = 0;
    initial begin
        o_svc_valid = 1'h0;
        o_svc_req = '0;
    end
    task automatic xfer(input logic wr, input logic [15:0] idn, input logic [31:0] wd,
                        output logic [31:0] rd, output logic er, output logic ak);
        repeat (gap) @(posedge i_clk);
        @(posedge i_clk);
        #1;
        o_svc_valid = 1'h1;
        o_svc_req = '{write: wr, idn: idn, wdata: wd};
        @(posedge i_clk);
        #1;
        o_svc_valid = 1'h0;
        // Released fields are inverted so a design that reads them late sees garbage.
        o_svc_req = ~o_svc_req;
        ak = i_svc_rsp.ack;
        er = i_svc_rsp.err;
        rd = i_svc_rsp.rdata;
    endtask
    task automatic cancel_homing(output logic ak);
        logic [31:0] rd;
        logic er;
        xfer(1'h1, IDN_HOMING_PROC, 32'h0000_0000, rd, er, ak);
    endtask
endmodule

// ==== tb/test_servo_homing_and_window_monitor.sv ====
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin err_total++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module test_servo_homing_and_window_monitor;
    timeunit 1ns;
    timeprecision 1ns;
    import servo_home_pkg::*;
    typedef struct {logic wr; logic [15:0] idn; logic [31:0] wd; logic [31:0] rd; logic er;} row_t;
    logic i_clk, i_resetn, i_svc_valid, i_class1_reset, i_home_switch, i_marker_pulse;
    svc_req_t i_svc_req;
    svc_rsp_t o_svc_rsp;
    logic [31:0] i_cyc_pos_cmd, i_cyc_vel_cmd, i_pos_fb, i_vel_fb;
    logic [31:0] o_pos_cmd, o_vel_cmd, rdv, i_homing_velocity, i_homing_accel, i_ref_distance;
    logic o_internal_pos_ctrl, o_referenced, erv, akv;
    proc_ack_t o_proc_ack;
    logic [15:0] i_ext_class1, o_class1_diag_word, o_class3_diag_word;
    int err_total = 0;
    int checks = 0;
    row_t rows[16] = '{
        '{1'h0, IDN_HOMING_CONFIG, 32'h0, 32'h0000_0004, 1'h0},
        '{1'h1, IDN_HOMING_CONFIG, 32'h0000_FFFF, 32'h0, 1'h0},
        '{1'h0, IDN_HOMING_CONFIG, 32'h0, 32'h0000_0067, 1'h0},
        '{1'h1, IDN_HOMING_CONFIG, 32'h0, 32'h0, 1'h0},
        '{1'h0, IDN_ACCEL_KIND, 32'h0, 32'h0000_0002, 1'h0},
        '{1'h1, IDN_ACCEL_KIND, 32'h0000_0005, 32'h0, 1'h1},
        '{1'h0, IDN_ACCEL_KIND, 32'h0, 32'h0000_0002, 1'h0},
        '{1'h0, IDN_ACCEL_MULT, 32'h0, 32'h0000_0001, 1'h0},
        '{1'h1, IDN_ACCEL_MULT, 32'h0000_0007, 32'h0, 1'h1},
        '{1'h0, IDN_SPEED_WINDOW, 32'h0, 32'h0, 1'h0},
        '{1'h1, IDN_SPEED_WINDOW, 32'h0001_0000, 32'h0, 1'h0},
        '{1'h0, IDN_SPEED_WINDOW, 32'h0, 32'h0000_8000, 1'h0},
        '{1'h0, IDN_POS_ERR_WINDOW, 32'h0, 32'h7FFF_FFFF, 1'h0},
        '{1'h1, IDN_POS_ERR_WINDOW, 32'hFFFF_FFFF, 32'h0, 1'h0},
        '{1'h0, IDN_POS_ERR_WINDOW, 32'h0, 32'h7FFF_FFFF, 1'h0},
        '{1'h0, 16'h0001, 32'h0, 32'h0, 1'h1}};
    servo_homing_and_window_monitor i_servo_homing_and_window_monitor (.*);
    svc_master_model i_svc_master_model (.i_clk(i_clk), .o_svc_valid(i_svc_valid),
        .o_svc_req(i_svc_req), .i_svc_rsp(o_svc_rsp));
    initial begin
        i_clk = 1'h0;
        forever #20 i_clk = ~i_clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic svc(input logic wr, input logic [15:0] idn, input logic [31:0] wd);
        i_svc_master_model.xfer(wr, idn, wd, rdv, erv, akv);
        `CHK("ack", 1'h1, akv)
    endtask
    task automatic home_start();
        svc(1'h1, IDN_HOMING_PROC, 32'h0000_0003);
        step(1);
        `CHK("internal", 1'h1, o_internal_pos_ctrl)
        `CHK("referenced", 1'h0, o_referenced)
    endtask
    task automatic cancel();
        i_svc_master_model.cancel_homing(akv);
        // Idle is reached one cycle after the cancel, cyclic control one cycle later.
        step(2);
        `CHK("internal", 1'h0, o_internal_pos_ctrl)
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #(40 * 4000);
        err_total++;
        complete_run();
    end
    initial begin
        {i_resetn, i_class1_reset, i_home_switch, i_marker_pulse} = 4'h0;
        {i_cyc_vel_cmd, i_vel_fb, i_ext_class1} = '0;
        {i_cyc_pos_cmd, i_pos_fb} = {32'd100, 32'd100};
        {i_homing_velocity, i_homing_accel} = {32'h0000_0008, 32'h0000_0002};
        i_ref_distance = 32'h0000_03E8;
        step(2);
        i_resetn = 1'h1;
        `CHK("referenced", 1'h0, o_referenced)
        `CHK("class1", 16'h0000, o_class1_diag_word)
        for (int k = 0; k < 16; k++) begin
            svc(rows[k].wr, rows[k].idn, rows[k].wd);
            `CHK("err", rows[k].er, erv)
            if (!rows[k].er) begin
                `CHK("rdata", rows[k].rd, rdv)
            end
        end
        $display("test table done");
        home_start();
        `CHK("busy", 1'h1, o_proc_ack.busy)
        i_cyc_pos_cmd = 32'h0000_5555;
        step(6);
        `CHK("vel_cmd", 32'd8, o_vel_cmd)
        `CHK("pos_cmd", 32'd100, o_pos_cmd)
        i_home_switch = 1'h1;
        step(4);
        i_pos_fb = 32'd200;
        i_marker_pulse = 1'h1;
        step(3);
        i_marker_pulse = 1'h0;
        for (int n = 0; n < 40 && o_proc_ack.done !== 1'h1; n++) step(1);
        `CHK("done", 1'h1, o_proc_ack.done)
        `CHK("referenced", 1'h1, o_referenced)
        `CHK("pos_cmd", 32'd1000, o_pos_cmd)
        `CHK("vel_cmd", 32'd0, o_vel_cmd)
        svc(1'h0, IDN_HOMING_PROC, 32'h0000_0000);
        `CHK("rdata", 32'h0000_0103, rdv)
        i_cyc_pos_cmd = 32'd1000;
        cancel();
        i_cyc_pos_cmd = 32'd1234;
        step(2);
        `CHK("pos_cmd", 32'd1234, o_pos_cmd)
        $display("test homing done");
        {i_home_switch, i_cyc_pos_cmd} = {1'h0, 32'd200};
        svc(1'h1, IDN_HOMING_CONFIG, 32'h0000_0001);
        home_start();
        step(6);
        `CHK("vel_cmd", 32'hFFFF_FFF8, o_vel_cmd)
        cancel();
        `CHK("referenced", 1'h0, o_referenced)
        home_start();
        i_ext_class1 = 16'h0001;
        step(3);
        `CHK("error", 1'h1, o_proc_ack.error)
        i_ext_class1 = 16'h0000;
        cancel();
        $display("test abort done");
        svc(1'h1, IDN_POS_ERR_WINDOW, 32'd10);
        i_cyc_pos_cmd = 32'd0;
        i_class1_reset = 1'h1;
        step(1);
        i_class1_reset = 1'h0;
        step(45);
        `CHK("deviation", 1'h0, o_class1_diag_word[C1_DEVIATION])
        step(15);
        `CHK("deviation", 1'h1, o_class1_diag_word[C1_DEVIATION])
        svc(1'h1, IDN_SPEED_WINDOW, 32'd16);
        {i_cyc_vel_cmd, i_vel_fb} = {32'd100, 32'd116};
        step(3);
        `CHK("speed_reached", 1'h1, o_class3_diag_word[C3_SPEED_REACHED])
        i_vel_fb = 32'd117;
        step(3);
        `CHK("speed_reached", 1'h0, o_class3_diag_word[C3_SPEED_REACHED])
        $display("test monitor done");
        i_resetn = 1'h0;
        step(1);
        `CHK("class1", 16'h0000, o_class1_diag_word)
        i_resetn = 1'h1;
        svc(1'h0, IDN_SPEED_WINDOW, 32'h0);
        `CHK("rdata", 32'h0, rdv)
        $display("test second reset done");
        i_vel_fb = 32'h0000_0000;
        svc(1'h1, IDN_HOMING_CONFIG, 32'h0000_0042);
        home_start();
        i_home_switch = 1'h1;
        step(12);
        `CHK("done", 1'h0, o_proc_ack.done)
        i_home_switch = 1'h0;
        for (int n = 0; n < 40 && o_proc_ack.done !== 1'h1; n++) step(1);
        `CHK("done", 1'h1, o_proc_ack.done)
        `CHK("pos_cmd", 32'h0000_03E8, o_pos_cmd)
        cancel();
        svc(1'h1, IDN_HOMING_CONFIG, 32'h0000_0060);
        home_start();
        for (int n = 0; n < 40 && o_proc_ack.done !== 1'h1; n++) step(1);
        `CHK("done", 1'h1, o_proc_ack.done)
        cancel();
        $display("test modes done");
        complete_run();
    end
endmodule
